// >>> src/nic_pkg.sv
// Package holding constants and types of the nested interrupt controller.
package nic_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NUM_VEC = 14;
  localparam int NUM_GRP = 4;
  localparam int GRP_PINS = 8;
  localparam int NUM_PRIO_REGS = 4;
  localparam int FIELDS_PER_REG = 4;

  // ==========================================================================
  // Register byte offsets on the APB bus
  // ==========================================================================
  localparam logic [7:0] OFS_VPRIO0 = 8'h00;
  localparam logic [7:0] OFS_VPRIO1 = 8'h04;
  localparam logic [7:0] OFS_VPRIO2 = 8'h08;
  localparam logic [7:0] OFS_VPRIO3 = 8'h0C;
  localparam logic [7:0] OFS_CUR_PRIO = 8'h10;
  localparam logic [7:0] OFS_TLI_CTRL = 8'h14;
  localparam logic [7:0] OFS_EXT_MASK = 8'h18;
  localparam logic [7:0] OFS_PENDING = 8'h1C;

  // ==========================================================================
  // Field layouts and reset values
  // ==========================================================================
  localparam logic [7:0] VPRIO_RST = 8'hFF;
  localparam logic [7:0] VPRIO3_RO_MASK = 8'hF0;
  localparam int CC_HIGH_POS = 5;
  localparam int CC_LOW_POS = 3;
  localparam logic [7:0] CC_FIXED_ONES = 8'hC0;
  localparam int TLI_EN_POS = 0;
  localparam int TLI_SENSE_POS = 1;
  localparam logic [31:0] EXT_MASK_RST = 32'h0000_0000;

  // ==========================================================================
  // Priority level codes in the current priority bits
  // ==========================================================================
  localparam logic [1:0] CODE_L0 = 2'h2;
  localparam logic [1:0] CODE_L1 = 2'h1;
  localparam logic [1:0] CODE_L2 = 2'h0;
  localparam logic [1:0] CODE_L3 = 2'h3;
  localparam logic [2:0] LVL_0 = 3'h0;
  localparam logic [2:0] LVL_1 = 3'h1;
  localparam logic [2:0] LVL_2 = 3'h2;
  localparam logic [2:0] LVL_3 = 3'h3;
  localparam logic [2:0] LVL_TOP = 3'h4;

  // ==========================================================================
  // Vector map
  // ==========================================================================
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_MASKABLE_BASE = 16'hFFFA;
  localparam int VEC_TLI = 0;
  localparam int VEC_EXT_FIRST = 2;
  localparam int VEC_EXT_LAST = 5;
  // Bit x set: vector x may end the halt modes.
  localparam logic [NUM_VEC-1:0] HALT_CAPABLE = 14'h21BF;

  // ==========================================================================
  // Core side types
  // ==========================================================================
  typedef enum logic [2:0] {
    INSTR_NONE = 3'h0,
    INSTR_ENABLE = 3'h1,
    INSTR_DISABLE = 3'h2,
    INSTR_HALT = 3'h3,
    INSTR_WAIT = 3'h4,
    INSTR_RETURN = 3'h5,
    INSTR_POP = 3'h6,
    INSTR_TRAP = 3'h7
  } nic_instr_t;

  typedef struct packed {
    logic boundary;
    nic_instr_t instr;
    logic [1:0] pop_prio;
    logic halted;
    logic entry_done;
  } nic_core_in_t;

  typedef struct packed {
    logic req;
    logic [15:0] vector;
    logic push;
    logic wake;
  } nic_core_out_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_ENTRY = 1'b1
  } nic_state_t;

endpackage

// >>> src/nic_pend_latch.sv
// Pending request latch for one interrupt vector.
`timescale 1ns/100ps

module nic_pend_latch
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_line,
  input wire logic i_edge_mode,
  input wire logic i_clr,
  output logic o_pend
);

  // ==========================================================================
  // Edge detection and latch
  // ==========================================================================
  logic line_reg;
  logic pend_reg;
  logic set_ev;

  // Edge mode fires once per rising edge; level mode follows the line.
  assign set_ev = i_edge_mode ? (i_line & ~line_reg) : i_line;

  // Previous line value for the edge detector.
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      line_reg <= 1'b0;
    else if (i_clk_en)
      line_reg <= i_line;
  end

  // A new event in the clearing cycle wins, so no request is lost.
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      pend_reg <= 1'b0;
    else if (i_clk_en)
    begin
      if (set_ev)
        pend_reg <= 1'b1;
      else if (i_clr)
        pend_reg <= 1'b0;
    end
  end

  assign o_pend = pend_reg;

endmodule

// >>> src/nic_ctrl.sv
// Nested priority interrupt controller with APB registers and core port.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps

module nic_ctrl
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_tli_pin,
  input wire logic [nic_pkg::NUM_GRP-1:0][nic_pkg::GRP_PINS-1:0] i_ext_pins,
  input wire logic [nic_pkg::NUM_VEC-1:0] i_periph_flag,
  input wire logic [nic_pkg::NUM_VEC-1:0] i_periph_en,
  input wire logic [nic_pkg::NUM_VEC-1:0] i_periph_clr,
  input wire nic_pkg::nic_core_in_t i_core,
  output nic_pkg::nic_core_out_t o_core
);

  // ==========================================================================
  // Helper functions
  // ==========================================================================

  // Level number of a two-bit priority code.
  function automatic logic [2:0] code_to_lvl(input logic [1:0] code);
    logic [2:0] lvl;
    lvl = nic_pkg::LVL_0;
    unique case (code)
      nic_pkg::CODE_L0: lvl = nic_pkg::LVL_0;
      nic_pkg::CODE_L1: lvl = nic_pkg::LVL_1;
      nic_pkg::CODE_L2: lvl = nic_pkg::LVL_2;
      nic_pkg::CODE_L3: lvl = nic_pkg::LVL_3;
    endcase
    return lvl;
  endfunction

  // Merge a write into a priority register field by field.
  function automatic logic [7:0] merge_prio(input logic [7:0] old_val,
                                            input logic [7:0] new_val);
    logic [7:0] res;
    res = old_val;
    for (int f = 0; f < nic_pkg::FIELDS_PER_REG; f++)
    begin
      if (new_val[2*f +: 2] != nic_pkg::CODE_L0)
        res[2*f +: 2] = new_val[2*f +: 2];
    end
    return res;
  endfunction

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [7:0] vprio_reg [nic_pkg::NUM_PRIO_REGS];
  logic [1:0] cur_prio_reg;
  logic tli_en_reg;
  logic tli_sense_reg;
  logic [31:0] ext_mask_reg;
  nic_pkg::nic_state_t state_reg;
  logic [15:0] vector_reg;
  logic push_reg;
  logic [nic_pkg::NUM_VEC-1:0] line;
  logic [nic_pkg::NUM_VEC-1:0] pend;
  logic [nic_pkg::NUM_VEC-1:0] clr;
  logic [nic_pkg::NUM_VEC-1:0] entry_clr;
  logic [nic_pkg::NUM_VEC-1:0] edge_mode;
  logic [1:0] field [nic_pkg::NUM_VEC];
  logic [2:0] eff_lvl;
  logic [1:0] eff_prio;
  logic any_elig;
  logic any_wait_wake;
  logic [3:0] best_v;
  logic [2:0] best_lvl;
  logic take;
  logic take_trap;
  logic take_mask;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_data;
  logic [31:0] rd_data_reg;

  // ==========================================================================
  // Request sources
  // ==========================================================================
  genvar gv;
  generate
    for (gv = 0; gv < nic_pkg::NUM_VEC; gv++)
    begin : g_src
      if (gv == nic_pkg::VEC_TLI)
      begin : g_tli
        // Sense bit picks the edge; the latch looks for a rising line.
        assign line[gv] = tli_en_reg &
                          (tli_sense_reg ? i_tli_pin : ~i_tli_pin);
        assign edge_mode[gv] = 1'b1;
      end
      else if (gv >= nic_pkg::VEC_EXT_FIRST && gv <= nic_pkg::VEC_EXT_LAST)
      begin : g_ext
        // Pins of a group that software enabled share one line.
        assign line[gv] = |(i_ext_pins[gv - nic_pkg::VEC_EXT_FIRST] &
          ext_mask_reg[nic_pkg::GRP_PINS*(gv - nic_pkg::VEC_EXT_FIRST)
                       +: nic_pkg::GRP_PINS]);
        assign edge_mode[gv] = 1'b1;
      end
      else
      begin : g_per
        assign line[gv] = i_periph_flag[gv] & i_periph_en[gv];
        assign edge_mode[gv] = 1'b0;
      end

      // Entry clears the latch; a clearing sequence discards it too.
      assign clr[gv] = entry_clr[gv] | i_periph_clr[gv];

      // Field x sits in register x/4 at bit 2*(x%4).
      assign field[gv] = vprio_reg[gv / nic_pkg::FIELDS_PER_REG]
                         [2*(gv % nic_pkg::FIELDS_PER_REG) +: 2];

      nic_pend_latch u_latch
      (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_clk_en(i_clk_en),
        .i_line(line[gv]),
        .i_edge_mode(edge_mode[gv]),
        .i_clr(clr[gv]),
        .o_pend(pend[gv])
      );
    end
  endgenerate

  // ==========================================================================
  // Instruction effect on the current level
  // ==========================================================================

  // The level that holds once the finishing instruction is applied.
  always_comb
  begin
    eff_prio = cur_prio_reg;
    if (i_core.boundary)
    begin
      unique case (i_core.instr)
        nic_pkg::INSTR_ENABLE,
        nic_pkg::INSTR_HALT,
        nic_pkg::INSTR_WAIT: eff_prio = nic_pkg::CODE_L0;
        nic_pkg::INSTR_DISABLE,
        nic_pkg::INSTR_TRAP: eff_prio = nic_pkg::CODE_L3;
        nic_pkg::INSTR_RETURN,
        nic_pkg::INSTR_POP: eff_prio = i_core.pop_prio;
        nic_pkg::INSTR_NONE: eff_prio = cur_prio_reg;
      endcase
    end
    eff_lvl = code_to_lvl(eff_prio);
  end

  // ==========================================================================
  // Priority decision
  // ==========================================================================

  // Ascending scan with strict compare keeps the lower index on ties,
  // which is the higher fixed priority.
  always_comb
  begin
    logic [2:0] lvl;
    lvl = nic_pkg::LVL_0;
    best_v = 4'h0;
    best_lvl = nic_pkg::LVL_0;
    any_elig = 1'b0;
    any_wait_wake = 1'b0;
    for (int v = 0; v < nic_pkg::NUM_VEC; v++)
    begin
      // The top-level field is ignored; it beats level 3 code.
      lvl = (v == nic_pkg::VEC_TLI) ? nic_pkg::LVL_TOP
                                    : code_to_lvl(field[v]);
      // A field raised above the running level re-enters at once.
      if (pend[v] && lvl > eff_lvl)
      begin
        any_wait_wake = 1'b1;
        // In halt only halt-capable sources compete for first service.
        if ((!i_core.halted || nic_pkg::HALT_CAPABLE[v]) &&
            (!any_elig || lvl > best_lvl))
        begin
          any_elig = 1'b1;
          best_v = 4'(v);
          best_lvl = lvl;
        end
      end
    end
  end

  // Decisions are made only at an instruction boundary, outside an entry.
  assign take_trap = i_core.boundary && state_reg == nic_pkg::ST_IDLE &&
                     i_core.instr == nic_pkg::INSTR_TRAP;
  assign take_mask = i_core.boundary && state_reg == nic_pkg::ST_IDLE &&
                     !take_trap && any_elig;
  assign take = take_trap | take_mask;

  // Latch of the entered vector is cleared in the take cycle.
  always_comb
  begin
    entry_clr = '0;
    if (take_mask)
      entry_clr[best_v] = 1'b1;
  end

  // ==========================================================================
  // Entry sequencer
  // ==========================================================================

  // Reset leaves the sequencer already presenting the reset vector.
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      state_reg <= nic_pkg::ST_ENTRY;
    else if (i_clk_en)
    begin
      unique case (state_reg)
        nic_pkg::ST_IDLE:
          if (take)
            state_reg <= nic_pkg::ST_ENTRY;
        nic_pkg::ST_ENTRY:
          if (i_core.entry_done)
            state_reg <= nic_pkg::ST_IDLE;
      endcase
    end
  end

  // Vector address and stacking flag of the entry being made.
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      vector_reg <= nic_pkg::VEC_RESET;
      push_reg <= 1'b0;
    end
    else if (i_clk_en && take)
    begin
      push_reg <= 1'b1;
      if (take_trap)
        vector_reg <= nic_pkg::VEC_TRAP;
      else
        vector_reg <= nic_pkg::VEC_MASKABLE_BASE -
                      {11'h000, best_v, 1'b0};
    end
  end

  // Current level: entry overrides the instruction, which overrides APB.
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      cur_prio_reg <= nic_pkg::CODE_L3;
    else if (i_clk_en)
    begin
      if (take_trap || (take_mask && best_v == 4'(nic_pkg::VEC_TLI)))
        cur_prio_reg <= nic_pkg::CODE_L3;
      else if (take_mask)
        cur_prio_reg <= field[best_v];
      else if (i_core.boundary && i_core.instr != nic_pkg::INSTR_NONE)
        cur_prio_reg <= eff_prio;
      else if (wr_en && i_paddr == nic_pkg::OFS_CUR_PRIO)
        cur_prio_reg <= {i_pwdata[nic_pkg::CC_HIGH_POS],
                         i_pwdata[nic_pkg::CC_LOW_POS]};
    end
  end

  // Wait ends on any unmasked request; halt only on halt-capable ones.
  assign o_core.wake = i_core.halted ? any_elig : any_wait_wake;
  assign o_core.req = state_reg == nic_pkg::ST_ENTRY;
  assign o_core.vector = vector_reg;
  assign o_core.push = push_reg;

  // ==========================================================================
  // APB slave
  // ==========================================================================
  assign wr_en = i_psel & i_penable & i_pwrite & i_clk_en;
  assign rd_en = i_psel & ~i_penable & ~i_pwrite;
  assign addr_ok = i_paddr <= nic_pkg::OFS_PENDING && i_paddr[1:0] == 2'h0;
  // Every access completes in its first access cycle.
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~addr_ok;

  // Priority registers, with the level 0 code filtered out per field.
  generate
    for (gv = 0; gv < nic_pkg::NUM_PRIO_REGS; gv++)
    begin : g_vprio
      always_ff @(posedge i_clk_sys or negedge i_nrst)
      begin
        if (!i_nrst)
          vprio_reg[gv] <= nic_pkg::VPRIO_RST;
        else if (wr_en && i_paddr == nic_pkg::OFS_VPRIO0 + 8'(4*gv))
        begin
          if (gv == nic_pkg::NUM_PRIO_REGS - 1)
            vprio_reg[gv] <= merge_prio(vprio_reg[gv], i_pwdata[7:0]) |
                             nic_pkg::VPRIO3_RO_MASK;
          else
            vprio_reg[gv] <= merge_prio(vprio_reg[gv], i_pwdata[7:0]);
        end
      end
    end
  endgenerate

  // Top-level control; the sense bit only moves while disabled.
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tli_en_reg <= 1'b0;
      tli_sense_reg <= 1'b0;
    end
    else if (wr_en && i_paddr == nic_pkg::OFS_TLI_CTRL)
    begin
      tli_en_reg <= i_pwdata[nic_pkg::TLI_EN_POS];
      if (!tli_en_reg)
        tli_sense_reg <= i_pwdata[nic_pkg::TLI_SENSE_POS];
    end
  end

  // Pin enables of the four external groups, one byte per group.
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      ext_mask_reg <= nic_pkg::EXT_MASK_RST;
    else if (wr_en && i_paddr == nic_pkg::OFS_EXT_MASK)
      ext_mask_reg <= i_pwdata;
  end

  // Read multiplexer; unmapped words read zero.
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (i_paddr)
      nic_pkg::OFS_VPRIO0: rd_data[7:0] = vprio_reg[0];
      nic_pkg::OFS_VPRIO1: rd_data[7:0] = vprio_reg[1];
      nic_pkg::OFS_VPRIO2: rd_data[7:0] = vprio_reg[2];
      nic_pkg::OFS_VPRIO3: rd_data[7:0] = vprio_reg[3];
      nic_pkg::OFS_CUR_PRIO:
      begin
        rd_data[7:0] = nic_pkg::CC_FIXED_ONES;
        rd_data[nic_pkg::CC_HIGH_POS] = cur_prio_reg[1];
        rd_data[nic_pkg::CC_LOW_POS] = cur_prio_reg[0];
      end
      nic_pkg::OFS_TLI_CTRL:
      begin
        rd_data[nic_pkg::TLI_EN_POS] = tli_en_reg;
        rd_data[nic_pkg::TLI_SENSE_POS] = tli_sense_reg;
      end
      nic_pkg::OFS_EXT_MASK: rd_data = ext_mask_reg;
      nic_pkg::OFS_PENDING: rd_data[nic_pkg::NUM_VEC-1:0] = pend;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Read data are captured in the setup cycle so prdata is a flop.
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      rd_data_reg <= 32'h0000_0000;
    else if (i_clk_en && rd_en)
      rd_data_reg <= rd_data;
  end

  assign o_prdata = rd_data_reg;

endmodule

// >>> tb/nic_ctrl_chk.sv
// Port checker of the nested interrupt controller.
`timescale 1ns/100ps
// ==========================================
// Checker
module nic_ctrl_chk
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire nic_pkg::nic_core_in_t i_core,
  input wire nic_pkg::nic_core_out_t o_core
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  a_reset_no_push: assert property (
    o_core.req && o_core.vector == nic_pkg::VEC_RESET |-> !o_core.push)
    else $error("reset entry pushed context");
  a_req_stands: assert property (
    o_core.req && !i_core.entry_done |=> o_core.req && $stable(o_core.vector))
    else $error("request dropped before entry done");
  a_done_ends: assert property (
    o_core.req && i_core.entry_done && i_clk_en |=> !o_core.req)
    else $error("request kept after entry done");
  a_trap_entry: assert property (
    i_core.boundary && i_core.instr == nic_pkg::INSTR_TRAP && !o_core.req
    && i_clk_en |=> o_core.req && o_core.vector == nic_pkg::VEC_TRAP
    && o_core.push) else $error("trap not entered");
  a_take_at_bound: assert property (
    $rose(o_core.req) |-> $past(i_core.boundary))
    else $error("entry started inside an instruction");
  a_vec_map: assert property (
    o_core.req |-> o_core.vector == nic_pkg::VEC_RESET
    || o_core.vector == nic_pkg::VEC_TRAP || (o_core.vector <= 16'hFFFA
    && o_core.vector >= 16'hFFE0 && !o_core.vector[0]))
    else $error("vector outside the map");
  a_apb_ready: assert property (i_psel && i_penable |-> o_pready)
    else $error("access not completed");
  a_slverr_map: assert property (i_psel && i_penable |-> o_pslverr ==
    (i_paddr > 8'h1C || i_paddr[1:0] != 2'h0))
    else $error("error response wrong");
  a_prdata_hold: assert property (!(i_psel && !i_penable) |=>
    $stable(o_prdata)) else $error("read data moved outside setup");
  c_trap: cover property (o_core.req && o_core.vector == nic_pkg::VEC_TRAP);
  c_nested: cover property (o_core.req && o_core.vector == 16'hFFEA);
  c_slverr: cover property (o_pslverr);
endmodule
bind nic_ctrl nic_ctrl_chk u_chk (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
  .i_clk_en(i_clk_en), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_core(i_core), .o_core(o_core));

// >>> tb/nic_core_mdl.sv
// Behavioural model of the CPU core facing the controller.
`timescale 1ns/100ps
module nic_core_mdl
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire nic_pkg::nic_core_out_t i_out,
  input wire logic i_go,
  input wire nic_pkg::nic_instr_t i_instr,
  input wire logic [1:0] i_pop,
  input wire logic i_halt,
  input wire logic [3:0] i_lat,
  output nic_pkg::nic_core_in_t o_in,
  output logic [15:0] o_vec,
  output logic o_push,
  output logic [7:0] o_takes
);
  logic [3:0] wait_reg;
  // No instruction ends while an entry runs; entry is done after i_lat.
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_in <= '0;
      wait_reg <= 4'h0;
      o_takes <= 8'h0;
      o_vec <= 16'h0;
      o_push <= 1'b0;
    end
    else
    begin
      o_in.boundary <= i_go && !i_out.req;
      o_in.instr <= i_go ? i_instr : nic_pkg::INSTR_NONE;
      o_in.pop_prio <= i_pop;
      o_in.halted <= i_halt;
      o_in.entry_done <= i_out.req && !o_in.entry_done && wait_reg == i_lat;
      wait_reg <= (i_out.req && !o_in.entry_done) ? wait_reg + 4'h1 : 4'h0;
      if (o_in.entry_done)
      begin
        o_vec <= i_out.vector;
        o_push <= i_out.push;
        o_takes <= o_takes + 8'h1;
      end
    end
  end
endmodule

// >>> tb/tb_nested_priority_interrupt_controller.sv
// Self-checking bench of the nested interrupt controller.
`timescale 1ns/100ps
module tb_nested_priority_interrupt_controller;
  logic clk, nrst, psel, penable, pwrite, top_level_request, go, hlt, err, push, ce;
  logic [7:0] paddr, takes;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr;
  logic [3:0][7:0] pins;
  logic [13:0] flag, en, clr;
  logic [1:0] pop;
  logic [3:0] lat;
  logic [15:0] vec;
  nic_pkg::nic_instr_t ins;
  nic_pkg::nic_core_in_t cin;
  nic_pkg::nic_core_out_t cout;
  int fail_count, checks_done;
  nic_pkg::nic_instr_t tab_i [6];
  logic [1:0] tab_c [6];
  nic_ctrl DUT (.i_clk_sys(clk), .i_nrst(nrst), .i_clk_en(ce),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_tli_pin(top_level_request), .i_ext_pins(pins),
    .i_periph_flag(flag), .i_periph_en(en), .i_periph_clr(clr),
    .i_core(cin), .o_core(cout));
  nic_core_mdl u_core (.i_clk_sys(clk), .i_nrst(nrst), .i_out(cout),
    .i_go(go), .i_instr(ins), .i_pop(pop), .i_halt(hlt), .i_lat(lat),
    .o_in(cin), .o_vec(vec), .o_push(push), .o_takes(takes));
  // The clock runs at 25 MHz.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic [13:0] f, input logic [13:0] e);
    @(posedge clk);
    flag <= f;
    en <= e;
    @(posedge clk);
    flag <= 14'h0;
  endtask
  // Ends one instruction and compares the entry it causes; zero means none.
  task automatic run(input nic_pkg::nic_instr_t i, input logic [1:0] p,
    input logic [15:0] ev);
    int n;
    n = takes;
    @(posedge clk);
    go <= 1'b1;
    ins <= i;
    pop <= p;
    @(posedge clk);
    go <= 1'b0;
    for (int k = 0; k < 20 && takes == n; k++)
      @(posedge clk);
    chk(takes == n ? 32'h0 : {16'h0, vec}, {16'h0, ev});
  endtask
  // A hang is cut short well after the tests should be over.
  initial
  begin
    #400000;
    fail_count++;
    wrap_up();
  end
  // ==========================================
  // Main sequence
  initial
  begin
    {nrst, psel, penable, pwrite, top_level_request, go, hlt} = 7'h0;
    {paddr, pwdata, pins, flag, en, clr, pop} = '0;
    ins = nic_pkg::INSTR_NONE;
    lat = 4'h1;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (int k = 0; k < 20 && takes == 8'h0; k++)
      @(posedge clk);
    chk({16'h0, vec}, 32'hFFFE);
    chk({31'h0, push}, 32'h0);
    apb(1'b0, nic_pkg::OFS_CUR_PRIO, 32'h0);
    chk(rd & 32'h28, 32'h28);
    for (int r = 0; r < 4; r++)
    begin
      apb(1'b0, 8'(4 * r), 32'h0);
      chk(rd & 32'hFF, 32'hFF);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, nic_pkg::OFS_VPRIO1, 32'hCF);
    apb(1'b1, nic_pkg::OFS_VPRIO1, 32'h64);
    apb(1'b0, nic_pkg::OFS_VPRIO1, 32'h0);
    chk(rd & 32'hFF, 32'h44);
    apb(1'b1, nic_pkg::OFS_VPRIO3, 32'h0);
    apb(1'b0, nic_pkg::OFS_VPRIO3, 32'h0);
    chk(rd & 32'hFF, 32'hF0);
    // A write while the clock enable is low must not land.
    ce <= 1'b0;
    apb(1'b1, nic_pkg::OFS_VPRIO0, 32'h55);
    ce <= 1'b1;
    apb(1'b0, nic_pkg::OFS_VPRIO0, 32'h0);
    chk(rd & 32'hFF, 32'hFF);
    tab_i = '{nic_pkg::INSTR_ENABLE, nic_pkg::INSTR_POP,
      nic_pkg::INSTR_DISABLE, nic_pkg::INSTR_WAIT, nic_pkg::INSTR_RETURN,
      nic_pkg::INSTR_HALT};
    tab_c = '{2'h2, 2'h1, 2'h3, 2'h2, 2'h0, 2'h2};
    for (int i = 0; i < 6; i++)
    begin
      run(tab_i[i], tab_c[i], 16'h0);
      apb(1'b0, nic_pkg::OFS_CUR_PRIO, 32'h0);
      chk(rd & 32'h28, {26'h0, tab_c[i][1], 1'b0,
        tab_c[i][0], 3'h0});
    end
    // Fields: 6 and 7 at level 1, 8 at level 2, nothing yet taken.
    apb(1'b1, nic_pkg::OFS_VPRIO1, 32'h5F);
    apb(1'b1, nic_pkg::OFS_VPRIO2, 32'hFC);
    pulse(14'h01C0, 14'h01C0);
    run(nic_pkg::INSTR_NONE, 2'h0, 16'hFFEA);
    apb(1'b0, nic_pkg::OFS_CUR_PRIO, 32'h0);
    chk(rd & 32'h28, 32'h0);
    run(nic_pkg::INSTR_NONE, 2'h0, 16'h0);
    run(nic_pkg::INSTR_RETURN, nic_pkg::CODE_L0, 16'hFFEE);
    run(nic_pkg::INSTR_RETURN, nic_pkg::CODE_L0, 16'hFFEC);
    pulse(14'h0200, 14'h0);
    apb(1'b0, nic_pkg::OFS_PENDING, 32'h0);
    chk(rd & 32'h200, 32'h0);
    run(nic_pkg::INSTR_DISABLE, 2'h0, 16'h0);
    pulse(14'h0400, 14'h0400);
    apb(1'b0, nic_pkg::OFS_PENDING, 32'h0);
    chk(rd & 32'h400, 32'h400);
    @(posedge clk);
    clr <= 14'h0400;
    @(posedge clk);
    clr <= 14'h0;
    apb(1'b0, nic_pkg::OFS_PENDING, 32'h0);
    chk(rd & 32'h400, 32'h0);
    // Slow entries from here on.
    lat <= 4'h3;
    run(nic_pkg::INSTR_TRAP, 2'h0, 16'hFFFC);
    chk({31'h0, push}, 32'h1);
    apb(1'b1, nic_pkg::OFS_TLI_CTRL, 32'h3);
    top_level_request <= 1'b1;
    apb(1'b0, nic_pkg::OFS_PENDING, 32'h0);
    chk(rd & 32'h1, 32'h1);
    run(nic_pkg::INSTR_NONE, 2'h0, 16'hFFFA);
    apb(1'b0, nic_pkg::OFS_CUR_PRIO, 32'h0);
    chk(rd & 32'h28, 32'h28);
    apb(1'b1, nic_pkg::OFS_EXT_MASK, 32'h4);
    pins[0] <= 8'h08;
    apb(1'b0, nic_pkg::OFS_PENDING, 32'h0);
    chk(rd & 32'h4, 32'h0);
    pins[0] <= 8'h00;
    apb(1'b1, nic_pkg::OFS_EXT_MASK, 32'hC);
    pins[0] <= 8'h08;
    apb(1'b0, nic_pkg::OFS_PENDING, 32'h0);
    chk(rd & 32'h4, 32'h4);
    run(nic_pkg::INSTR_RETURN, nic_pkg::CODE_L0, 16'hFFF6);
    apb(1'b0, nic_pkg::OFS_PENDING, 32'h0);
    chk(rd & 32'h4, 32'h0);
    // Halt: 9 is not halt-capable at level 2, 8 is at level 1.
    apb(1'b1, nic_pkg::OFS_VPRIO2, 32'hF1);
    hlt <= 1'b1;
    run(nic_pkg::INSTR_HALT, 2'h0, 16'h0);
    pulse(14'h0200, 14'h0200);
    @(negedge clk);
    chk({31'h0, cout.wake}, 32'h0);
    pulse(14'h0100, 14'h0100);
    @(negedge clk);
    chk({31'h0, cout.wake}, 32'h1);
    run(nic_pkg::INSTR_NONE, 2'h0, 16'hFFEA);
    hlt <= 1'b0;
    run(nic_pkg::INSTR_NONE, 2'h0, 16'hFFE8);
    // Vector 9 pends again at the running level, then its field is raised.
    pulse(14'h0200, 14'h0200);
    run(nic_pkg::INSTR_NONE, 2'h0, 16'h0);
    apb(1'b1, nic_pkg::OFS_VPRIO2, 32'hFD);
    run(nic_pkg::INSTR_NONE, 2'h0, 16'hFFE8);
    wrap_up();
  end
endmodule
